/* File: hdl/hwsup_pkg.sv */
// Package: constants, types and register map of the host watchdog supervisor
package hwsup_pkg;

   // ==========================================================
   // Clock and time base
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned SEC_CYCLES = CLK_HZ / 1;
   localparam int unsigned HOST_RST_MS = 200;
   localparam int unsigned HOST_RST_CYCLES = (CLK_HZ / 1000) * HOST_RST_MS;

   // ==========================================================
   // Delays in seconds
   localparam logic [16:0] POD_SECONDS = 17'd150;
   localparam logic [2:0] RELAY_PULSE_TICKS = 3'd5;
   localparam logic [16:0] TMO_SEL_0 = 17'd5;
   localparam logic [16:0] TMO_SEL_1 = 17'd10;
   localparam logic [16:0] TMO_SEL_2 = 17'd30;
   localparam logic [16:0] TMO_SEL_3 = 17'd60;
   localparam logic [16:0] TMO_SEL_4 = 17'd300;
   localparam logic [16:0] TMO_SEL_5 = 17'd600;
   localparam logic [16:0] TMO_SEL_6 = 17'd1800;
   localparam logic [16:0] TMO_SEL_7 = 17'd3600;

   // ==========================================================
   // Temperature trip points in degrees C
   localparam logic [7:0] LOWER_TRIP_RST = 8'h2e;
   localparam logic [7:0] UPPER_TRIP_RST = 8'h38;
   localparam logic [7:0] LOWER_TRIP_MAX = 8'h4d;
   localparam logic [7:0] UPPER_TRIP_MAX = 8'h57;
   localparam logic [7:0] HOLD_RELEASE_MARGIN = 8'h04;

   // ==========================================================
   // Register byte offsets
   localparam logic [11:0] CTRL_OFF = 12'h000;
   localparam logic [11:0] STATUS_OFF = 12'h004;
   localparam logic [11:0] KICK_OFF = 12'h008;
   localparam logic [11:0] TIMEOUT_OFF = 12'h00c;
   localparam logic [11:0] TRIP_OFF = 12'h010;
   localparam logic [11:0] COUNT_OFF = 12'h014;

   // Control register fields
   localparam int CTRL_RELAY_CLR_BIT = 0;
   localparam int CTRL_R1_INVERT_BIT = 1;
   localparam int CTRL_R2_OWN_BIT = 2;
   localparam int CTRL_R2_VALUE_BIT = 3;
   localparam logic [3:0] CTRL_RST = 4'h0;

   // ==========================================================
   // Supervisor states, Gray along pod, extend, armed, reset
   typedef enum logic [1:0] {
      HWSUP_POD = 2'b00,
      HWSUP_EXTEND = 2'b01,
      HWSUP_ARMED = 2'b11,
      HWSUP_RESET = 2'b10
   } hwsup_state_e;

   // Board switch bundle
   typedef struct packed {
      logic relay1_temperature_follow;
      logic relay1_latch_select;
      logic relay2_latch_select;
      logic overtemp_hold_reset_enable;
      logic power_on_delay_extend;
      logic [2:0] timeout_select;
   } hwsup_dip_s;

endpackage

/* File: hdl/hwsup_top.sv */
// Host watchdog supervisor: countdown, relays, temperature trips, APB registers
// Overview of operation
// - Wait start-up delay after any host reset
// - Then arm and start selected countdown
// - Expiry without activity resets the host
// - Timeout reset lights sticky trip indicator
// - Readable status bit marks watchdog reset
// - Control port write clears status and indicator
// - Watchdog reset fires both relays per mode
// - Software clears relays; option inverts relay one
// - Lower trip raises alarm and trip output
// - Software raises trip points, 1 C steps, capped
// - Relay one follows lower trip when enabled
// - Relay one latches or pulses 4-5 s
// - Relay two latches or pulses 4-5 s
// - Software may own relay two exclusively
// - Upper trip holds reset until lower+4
// - Without hold, upper trip changes alarm sound
// - Extend switch waits for first re-trigger
// - Three switches select the timeout
// - Each re-trigger reloads the full timeout
// - Software timeout overrides switch setting
// - Trip output released at or below lower point
// - Only trigger rising edges re-trigger; kick register writes also do
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module hwsup_top
#(
   parameter int unsigned TICK_CYCLES = hwsup_pkg::SEC_CYCLES,
   parameter int unsigned RST_CYCLES = hwsup_pkg::HOST_RST_CYCLES
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Board pins in
   input wire hwsup_pkg::hwsup_dip_s dip,
   input wire logic ext_trigger,
   input wire logic [7:0] temp_c,
   // Board pins out
   output logic host_reset_n,
   output logic trip_led,
   output logic relay1_on,
   output logic relay2_on,
   output logic temp_trip_o,
   output logic temp_trip_oe,
   output logic alarm_beep,
   output logic alarm_steady
);
   import hwsup_pkg::*;

   // Elaboration checks: counters are 28 and 26 bits wide
   if (TICK_CYCLES < 2 || TICK_CYCLES > 32'd268435455)
   begin
      $error("TICK_CYCLES out of range");
   end
   if (RST_CYCLES < 1 || RST_CYCLES > 32'd67108863)
   begin
      $error("RST_CYCLES out of range");
   end

   // ==========================================================
   // Helper functions
   // Switch code to timeout seconds
   function automatic logic [16:0] sel_seconds(input logic [2:0] sel);
      case (sel)
         3'h0: sel_seconds = TMO_SEL_0;
         3'h1: sel_seconds = TMO_SEL_1;
         3'h2: sel_seconds = TMO_SEL_2;
         3'h3: sel_seconds = TMO_SEL_3;
         3'h4: sel_seconds = TMO_SEL_4;
         3'h5: sel_seconds = TMO_SEL_5;
         3'h6: sel_seconds = TMO_SEL_6;
         default: sel_seconds = TMO_SEL_7;
      endcase
   endfunction

   // Keep a trip point within its legal band
   function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
      if (v < lo)
         clamp = lo;
      else if (v > hi)
         clamp = hi;
      else
         clamp = v;
   endfunction

   // ==========================================================
   // Input synchronisers; temperature is assumed to move slowly
   hwsup_dip_s dip_s1_reg, dip_s2_reg;
   logic trig_s1_reg, trig_s2_reg, trig_s3_reg;
   logic [7:0] temp_s1_reg, temp_s2_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dip_s1_reg <= '0;
         dip_s2_reg <= '0;
         trig_s1_reg <= 1'b0;
         trig_s2_reg <= 1'b0;
         trig_s3_reg <= 1'b0;
         temp_s1_reg <= 8'h00;
         temp_s2_reg <= 8'h00;
      end
      else
      begin
         dip_s1_reg <= dip;
         dip_s2_reg <= dip_s1_reg;
         trig_s1_reg <= ext_trigger;
         trig_s2_reg <= trig_s1_reg;
         trig_s3_reg <= trig_s2_reg;
         temp_s1_reg <= temp_c;
         temp_s2_reg <= temp_s1_reg;
      end
   end

   // ==========================================================
   // APB slave: one wait state, registered answer
   logic [3:0] ctrl_reg;
   logic [16:0] tmo_sw_reg;
   logic [7:0] lower_reg, upper_reg;
   logic wd_flag_reg;
   logic hold_reg;
   logic relay1_act_reg, relay2_act_reg;
   logic [16:0] count_reg;
   hwsup_state_e state_reg;
   logic wr_go, ctrl_wr, kick_wr, mapped;

   always_comb
   begin
      wr_go = psel && penable && pready && pwrite;
      ctrl_wr = wr_go && (paddr == CTRL_OFF);
      kick_wr = wr_go && (paddr == KICK_OFF);
      mapped = (paddr == CTRL_OFF) || (paddr == STATUS_OFF) || (paddr == KICK_OFF) ||
               (paddr == TIMEOUT_OFF) || (paddr == TRIP_OFF) || (paddr == COUNT_OFF);
   end

   // Answer is built while pready is low, so data reflects that cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         prdata <= 32'h0000_0000;
         if (psel && penable && !pready && !pwrite)
         begin
            case (paddr)
               CTRL_OFF: prdata <= {28'h0, ctrl_reg};
               STATUS_OFF: prdata <= {23'h0, relay2_act_reg, relay1_act_reg, hold_reg,
                                      1'b0, 1'b0, state_reg, wd_flag_reg, wd_flag_reg};
               TIMEOUT_OFF: prdata <= {15'h0, tmo_sw_reg};
               TRIP_OFF: prdata <= {16'h0, upper_reg, lower_reg};
               COUNT_OFF: prdata <= {15'h0, count_reg};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Software settings
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= CTRL_RST;
         tmo_sw_reg <= 17'h0;
         lower_reg <= LOWER_TRIP_RST;
         upper_reg <= UPPER_TRIP_RST;
      end
      else if (wr_go)
      begin
         if (paddr == CTRL_OFF)
            ctrl_reg <= pwdata[3:0];
         if (paddr == TIMEOUT_OFF)
            tmo_sw_reg <= pwdata[16:0];
         if (paddr == TRIP_OFF)
         begin
            lower_reg <= clamp(pwdata[7:0], LOWER_TRIP_RST, LOWER_TRIP_MAX);
            upper_reg <= clamp(pwdata[15:8], UPPER_TRIP_RST, UPPER_TRIP_MAX);
         end
      end
   end

   // ==========================================================
   // One-second tick
   logic [27:0] tick_cnt_reg;
   logic tick;

   assign tick = (tick_cnt_reg == 28'h0);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tick_cnt_reg <= 28'h0;
      else if (tick)
         tick_cnt_reg <= 28'(TICK_CYCLES - 1);
      else
         tick_cnt_reg <= tick_cnt_reg - 28'h1;
   end

   // ==========================================================
   // Temperature compare
   logic temp_lo, temp_hi, temp_cool, temp_lo_d_reg, relay1_temp_fire;

   always_comb
   begin
      temp_lo = temp_s2_reg > lower_reg;
      temp_hi = temp_s2_reg >= upper_reg;
      temp_cool = temp_s2_reg <= (lower_reg + HOLD_RELEASE_MARGIN);
      relay1_temp_fire = dip_s2_reg.relay1_temperature_follow && temp_lo &&
                         !temp_lo_d_reg;
   end

   // Over-temperature hold; release restarts the start-up delay
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hold_reg <= 1'b0;
         temp_lo_d_reg <= 1'b0;
      end
      else
      begin
         temp_lo_d_reg <= temp_lo;
         if (dip_s2_reg.overtemp_hold_reset_enable && temp_hi)
            hold_reg <= 1'b1;
         else if (temp_cool)
            hold_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Supervisor sequence
   logic [16:0] timeout_s;
   logic retrig, expire, wd_fire;
   logic [25:0] rst_cnt_reg;

   always_comb
   begin
      timeout_s = (tmo_sw_reg != 17'h0) ? tmo_sw_reg : sel_seconds(dip_s2_reg.timeout_select);
      retrig = kick_wr || (trig_s2_reg && !trig_s3_reg);
      // A held host is not a watchdog trip; hold already forces the start-up delay
      expire = (state_reg == HWSUP_ARMED) && tick && (count_reg == 17'h0) && !retrig &&
               !hold_reg;
      wd_fire = expire;
   end

   // Countdown runs in whole seconds, so expiry lands N to N+1 s after load
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= HWSUP_POD;
         count_reg <= POD_SECONDS;
         rst_cnt_reg <= 26'h0;
      end
      else if (hold_reg)
      begin
         state_reg <= HWSUP_POD;
         count_reg <= POD_SECONDS;
      end
      else
      begin
         case (state_reg)
            HWSUP_POD:
            begin
               if (tick && count_reg == 17'h0)
               begin
                  count_reg <= timeout_s;
                  if (dip_s2_reg.power_on_delay_extend)
                     state_reg <= HWSUP_EXTEND;
                  else
                     state_reg <= HWSUP_ARMED;
               end
               else if (tick)
                  count_reg <= count_reg - 17'h1;
            end
            HWSUP_EXTEND:
            begin
               count_reg <= timeout_s;
               if (retrig)
                  state_reg <= HWSUP_ARMED;
            end
            HWSUP_ARMED:
            begin
               if (retrig)
                  count_reg <= timeout_s;
               else if (expire)
               begin
                  state_reg <= HWSUP_RESET;
                  rst_cnt_reg <= 26'(RST_CYCLES - 1);
               end
               else if (tick)
                  count_reg <= count_reg - 17'h1;
            end
            HWSUP_RESET:
            begin
               if (rst_cnt_reg == 26'h0)
               begin
                  state_reg <= HWSUP_POD;
                  count_reg <= POD_SECONDS;
               end
               else
                  rst_cnt_reg <= rst_cnt_reg - 26'h1;
            end
            default:
               state_reg <= HWSUP_POD;
         endcase
      end
   end

   // Sticky flag; a new watchdog reset wins over a clearing write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wd_flag_reg <= 1'b0;
      else if (wd_fire)
         wd_flag_reg <= 1'b1;
      else if (ctrl_wr)
         wd_flag_reg <= 1'b0;
   end

   // ==========================================================
   // Relays; pulse counts whole ticks so the first is partial (4-5 s)
   logic [2:0] r1_cnt_reg, r2_cnt_reg;
   logic r1_inv, r1_latch, r1_fire, relay_clr;

   always_comb
   begin
      r1_inv = ctrl_reg[CTRL_R1_INVERT_BIT];
      r1_latch = dip_s2_reg.relay1_latch_select ^ r1_inv;
      r1_fire = wd_fire || relay1_temp_fire;
      relay_clr = ctrl_wr && pwdata[CTRL_RELAY_CLR_BIT];
   end

   // Relay one state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         relay1_act_reg <= 1'b0;
         r1_cnt_reg <= 3'h0;
      end
      else if (r1_fire)
      begin
         relay1_act_reg <= 1'b1;
         r1_cnt_reg <= RELAY_PULSE_TICKS;
      end
      else if (relay_clr)
         relay1_act_reg <= 1'b0;
      else if (tick && !r1_latch && relay1_act_reg)
      begin
         r1_cnt_reg <= r1_cnt_reg - 3'h1;
         if (r1_cnt_reg <= 3'h1)
            relay1_act_reg <= 1'b0;
      end
   end

   // Relay two state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         relay2_act_reg <= 1'b0;
         r2_cnt_reg <= 3'h0;
      end
      else if (wd_fire)
      begin
         relay2_act_reg <= 1'b1;
         r2_cnt_reg <= RELAY_PULSE_TICKS;
      end
      else if (relay_clr)
         relay2_act_reg <= 1'b0;
      else if (tick && !dip_s2_reg.relay2_latch_select && relay2_act_reg)
      begin
         r2_cnt_reg <= r2_cnt_reg - 3'h1;
         if (r2_cnt_reg <= 3'h1)
            relay2_act_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Registered pin outputs
   logic trip_led_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         host_reset_n <= 1'b1;
         trip_led_reg <= 1'b0;
         relay1_on <= 1'b0;
         relay2_on <= 1'b0;
         temp_trip_o <= 1'b0;
         temp_trip_oe <= 1'b0;
         alarm_beep <= 1'b0;
         alarm_steady <= 1'b0;
      end
      else
      begin
         host_reset_n <= !((state_reg == HWSUP_RESET) || hold_reg);
         if (wd_fire)
            trip_led_reg <= 1'b1;
         else if (ctrl_wr)
            trip_led_reg <= 1'b0;
         relay1_on <= relay1_act_reg ^ r1_inv;
         relay2_on <= ctrl_reg[CTRL_R2_OWN_BIT] ? ctrl_reg[CTRL_R2_VALUE_BIT] :
                      relay2_act_reg;
         temp_trip_o <= 1'b0;
         temp_trip_oe <= temp_lo;
         alarm_beep <= temp_lo && !(temp_hi && !dip_s2_reg.overtemp_hold_reset_enable);
         alarm_steady <= temp_hi && !dip_s2_reg.overtemp_hold_reset_enable;
      end
   end

   assign trip_led = trip_led_reg;

   // ==========================================================
   // Assertions
   a_flag_on_fire: assert property (@(posedge pclk) disable iff (!presetn)
      wd_fire |=> wd_flag_reg && trip_led_reg) else $error("Flag not set on expiry");
   a_ctrl_clears: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_wr && !wd_fire |=> !wd_flag_reg ##0 !trip_led_reg) else $error("Clear ignored");
   a_expire_resets: assert property (@(posedge pclk) disable iff (!presetn)
      expire |=> state_reg == HWSUP_RESET ##1 !host_reset_n) else $error("No host reset");
   a_retrig_reload: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == HWSUP_ARMED && retrig && !hold_reg |=> count_reg == $past(timeout_s))
      else $error("Countdown not reloaded");
   a_trip_output: assert property (@(posedge pclk) disable iff (!presetn)
      temp_trip_oe == $past(temp_lo) && !temp_trip_o) else $error("Trip output wrong");
   a_hold_reset: assert property (@(posedge pclk) disable iff (!presetn)
      hold_reg |=> !host_reset_n) else $error("Hold not driving reset");
   a_alarm_tone: assert property (@(posedge pclk) disable iff (!presetn)
      temp_hi && !dip_s2_reg.overtemp_hold_reset_enable |=> alarm_steady && !hold_reg)
      else $error("Second trip tone missing");
   a_relay2_owned: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_reg[CTRL_R2_OWN_BIT] |=> relay2_on == $past(ctrl_reg[CTRL_R2_VALUE_BIT]))
      else $error("Relay two not under software");
   a_extend_waits: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == HWSUP_EXTEND && !retrig && !hold_reg |=> state_reg == HWSUP_EXTEND)
      else $error("Armed without re-trigger");
   a_relays_fire: assert property (@(posedge pclk) disable iff (!presetn)
      wd_fire |=> relay1_act_reg && relay2_act_reg) else $error("Relays not fired");

   c_wd_expiry: cover property (@(posedge pclk) disable iff (!presetn) expire);
   c_temp_hold: cover property (@(posedge pclk) disable iff (!presetn) hold_reg);
   c_extend_arm: cover property (@(posedge pclk) disable iff (!presetn)
      state_reg == HWSUP_EXTEND ##1 state_reg == HWSUP_ARMED);

endmodule

`default_nettype wire

/* File: verif/hwsup_host_model.sv */
// Host side model: heartbeat on the trigger pin and host reset counter
`timescale 1ns/10ps
`default_nettype none

module hwsup_host_model
#(
   parameter int PERIOD = 30
)
(
   // Clock and host state
   input wire logic pclk,
   input wire logic host_reset_n,
   input wire logic beat_en,
   // Trigger pin and observation
   output logic ext_trigger,
   output int n_resets
);
   int cnt;

   // Quiet pin and zero count until the host starts
   initial
   begin
      cnt = 0;
      ext_trigger = 1'b0;
      n_resets = 0;
   end

   // Heartbeat well inside the timeout; a host held in reset stays silent
   always @(posedge pclk)
   begin
      cnt <= (cnt + 1) % PERIOD;
      ext_trigger <= beat_en && host_reset_n && (cnt < PERIOD / 2);
   end

   // Every reset the supervisor pulls on the host
   always @(negedge host_reset_n)
      n_resets <= n_resets + 1;
endmodule

`default_nettype wire

/* File: verif/tb.sv */
// Testbench: APB call sequences against the host watchdog supervisor
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end

module tb;
   import hwsup_pkg::*;
   localparam int TK = 20;
   localparam int RC = 8;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr;
   hwsup_dip_s dip = 8'h27;
   logic ext_trigger;
   logic [7:0] temp_c = 8'h19;
   logic host_reset_n, trip_led, relay1_on, relay2_on;
   logic temp_trip_o, temp_trip_oe, alarm_beep, alarm_steady;
   logic beat_en = 1'b0;
   int n_resets;
   int n_errors = 0;
   int samples_checked = 0;
   logic [31:0] rd;
   logic err;

   // ==========================================================
   // Clock, design and host model
   always #2.5 pclk = ~pclk;

   hwsup_top #(.TICK_CYCLES(TK), .RST_CYCLES(RC)) u_hwsup_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .dip(dip), .ext_trigger(ext_trigger),
      .temp_c(temp_c), .host_reset_n(host_reset_n), .trip_led(trip_led),
      .relay1_on(relay1_on), .relay2_on(relay2_on), .temp_trip_o(temp_trip_o),
      .temp_trip_oe(temp_trip_oe), .alarm_beep(alarm_beep),
      .alarm_steady(alarm_steady));

   hwsup_host_model #(.PERIOD(30)) u_hwsup_host_model (
      .pclk(pclk), .host_reset_n(host_reset_n), .beat_en(beat_en),
      .ext_trigger(ext_trigger), .n_resets(n_resets));

   // ==========================================================
   // Verdict and run end
   task automatic end_sim();
      if (n_errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (i == 16)
      begin
         n_errors++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Registered outputs need a couple of edges to follow a write
      repeat (3) @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdx(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   // Bounded waits; running out counts as a mismatch
   task automatic wait_rst(input logic v, input int bound);
      int i;
      for (i = 0; i < bound; i++)
      begin
         @(posedge pclk);
         if (host_reset_n === v)
            break;
      end
      if (i == bound)
      begin
         n_errors++;
         end_sim();
      end
   endtask

   task automatic wait_state(input logic [1:0] s, input int bound);
      int i;
      for (i = 0; i < bound; i++)
      begin
         rdx(STATUS_OFF);
         if (rd[3:2] === s)
            break;
      end
      if (i == bound)
      begin
         n_errors++;
         end_sim();
      end
   endtask

   // Hang guard
   initial
   begin
      repeat (60000) @(posedge pclk);
      n_errors++;
      end_sim();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK({host_reset_n, trip_led, relay1_on, relay2_on, temp_trip_oe}, 5'h10)
      rdx(STATUS_OFF);
      `CHK(rd, 32'h0)
      rdx(TRIP_OFF);
      `CHK(rd, {16'h0, UPPER_TRIP_RST, LOWER_TRIP_RST})
      rdx(12'h018);
      `CHK(err, 1'b1)
      wr(TRIP_OFF, 32'h0000_392f);
      rdx(TRIP_OFF);
      `CHK(rd, 32'h0000_392f)
      wr(TRIP_OFF, 32'h0000_1060);
      rdx(TRIP_OFF);
      `CHK(rd, {16'h0, UPPER_TRIP_RST, LOWER_TRIP_MAX})
      wr(TRIP_OFF, 32'h0000_382e);
      wr(TIMEOUT_OFF, 32'h3);
      rdx(TIMEOUT_OFF);
      `CHK(rd, 32'h3)
      // Start-up delay, then arming on a 3 s software timeout over the 1 h switches
      repeat (140 * TK - 200) @(posedge pclk);
      rdx(STATUS_OFF);
      `CHK(rd[3:2], 2'b00)
      wait_state(2'b11, 100);
      repeat (10)
      begin
         wr(KICK_OFF, 32'h0);
         repeat (30) @(posedge pclk);
      end
      beat_en <= 1'b1;
      repeat (300) @(posedge pclk);
      beat_en <= 1'b0;
      `CHK(n_resets, 0)
      wait_rst(1'b0, 6 * TK);
      `CHK({trip_led, relay1_on, relay2_on}, 3'b111)
      rdx(STATUS_OFF);
      `CHK(rd[1:0], 2'b11)
      repeat (3 * TK) @(posedge pclk);
      `CHK(relay1_on, 1'b1)
      repeat (3 * TK) @(posedge pclk);
      `CHK({relay1_on, relay2_on, trip_led}, 3'b011)
      // Control writes: clears, relay two ownership, relay one inversion
      wr(CTRL_OFF, 32'h1);
      wr(CTRL_OFF, 32'h0);
      `CHK({trip_led, relay2_on}, 2'b00)
      rdx(STATUS_OFF);
      `CHK(rd[1:0], 2'b00)
      wr(CTRL_OFF, 32'hc);
      `CHK(relay2_on, 1'b1)
      wr(CTRL_OFF, 32'h4);
      `CHK(relay2_on, 1'b0)
      wr(CTRL_OFF, 32'h2);
      `CHK(relay1_on, 1'b1)
      wr(CTRL_OFF, 32'h0);
      `CHK(relay1_on, 1'b0)
      // Extended start-up waits for a re-trigger; switches give 5 s
      dip.power_on_delay_extend <= 1'b1;
      dip.timeout_select <= 3'b000;
      wr(TIMEOUT_OFF, 32'h0);
      wait_state(2'b01, 1000);
      repeat (5 * TK) @(posedge pclk);
      rdx(STATUS_OFF);
      `CHK(rd[3:2], 2'b01)
      wr(KICK_OFF, 32'h0);
      rdx(STATUS_OFF);
      `CHK(rd[3:2], 2'b11)
      rdx(COUNT_OFF);
      `CHK((rd >= 32'd4 && rd <= 32'd5), 1'b1)
      dip.power_on_delay_extend <= 1'b0;
      wait_rst(1'b0, 7 * TK);
      wait_rst(1'b1, 4 * RC);
      repeat (6 * TK) @(posedge pclk);
      // Temperature trips
      dip.relay1_temperature_follow <= 1'b1;
      temp_c <= 8'd47;
      repeat (6) @(posedge pclk);
      `CHK({temp_trip_oe, temp_trip_o}, 2'b10)
      `CHK({alarm_beep, relay1_on}, 2'b11)
      temp_c <= 8'd46;
      repeat (6) @(posedge pclk);
      `CHK(temp_trip_oe, 1'b0)
      dip.overtemp_hold_reset_enable <= 1'b1;
      temp_c <= 8'd56;
      wait_rst(1'b0, 10);
      temp_c <= 8'd51;
      repeat (10) @(posedge pclk);
      `CHK(host_reset_n, 1'b0)
      temp_c <= 8'd50;
      wait_rst(1'b1, 10);
      dip.overtemp_hold_reset_enable <= 1'b0;
      temp_c <= 8'd56;
      repeat (6) @(posedge pclk);
      `CHK({alarm_steady, alarm_beep, host_reset_n}, 3'b101)
      end_sim();
   end
endmodule

`undef CHK
`default_nettype wire
